// file: gst_params.svh
// constants of the group self-tuning coordinator: offsets, fields, reset values, timing
`ifndef GST_PARAMS_SVH
`define GST_PARAMS_SVH
`define GST_LOOPS 8
`define GST_CLK_HZ 50000000
`define GST_TICK_PER_S 1000
`define GST_REST_TIME_S 90
`define GST_HOUR_TIME_S 3600
`define GST_REST_W 17
`define GST_HOUR_W 22
`define GST_TICK_W 16
`define GST_OFS_CTRL 8'h00
`define GST_OFS_MEMBER 8'h04
`define GST_OFS_START 8'h08
`define GST_OFS_THREEPT 8'h0C
`define GST_OFS_STATUS 8'h10
`define GST_OFS_SPAN 8'h14
`define GST_BASE_STABLE 8'h20
`define GST_BASE_CODE 8'h40
`define GST_BASE_PSET0 8'h60
`define GST_BASE_PSET1 8'h80
`define GST_CTRL_GRP 0
`define GST_CTRL_ACT 1
`define GST_CTRL_TGT 2
`define GST_RST_SPAN 16'h03E8
`define GST_RST_STABLE 8'h00
`define GST_RST_PSET0 16'h0064
`define GST_RST_PSET1 16'h0064
`define GST_MIN_STEP_PCT 8'h05
`define GST_CODE_NONE 4'h0
`define GST_CODE_OK 4'h2
`define GST_CODE_SLOW 4'h3
`define GST_CODE_LOWREV 4'h4
`define GST_CODE_OVR 4'h5
`define GST_CODE_EARLY 4'h6
`define GST_CODE_STEP 4'h7
`define GST_CODE_REST 4'h8
`endif

// file: gst_pkg.sv
// types of the group self-tuning coordinator
`include "gst_params.svh"
package gst_pkg;
  typedef enum logic [5:0] {
    GST_IDLE = 6'h01,
    GST_REST = 6'h02,
    GST_HEAT = 6'h04,
    GST_COOLW = 6'h08,
    GST_COOL = 6'h10,
    GST_ERR = 6'h20
  } gst_loop_e;

  typedef struct packed {
    logic ack;
    logic [31:0] rdata;
    logic grp_start;
    logic grp_active;
    logic act_set;
    logic tgt_set;
    logic dsel_q;
    logic [`GST_LOOPS-1:0] member;
    logic [`GST_LOOPS-1:0] three_pt;
    logic [`GST_LOOPS-1:0] start;
    logic [`GST_LOOPS-1:0] reacted;
    logic [15:0] span;
    logic [`GST_TICK_W-1:0] tick_cnt;
    logic tick;
    logic [`GST_LOOPS-1:0][7:0] stable;
    logic [`GST_LOOPS-1:0][3:0] code;
    logic [1:0][`GST_LOOPS-1:0][15:0] pset;
    gst_loop_e [`GST_LOOPS-1:0] lst;
    logic [`GST_LOOPS-1:0][15:0] rest_ref;
    logic [`GST_LOOPS-1:0][`GST_REST_W-1:0] rest_cnt;
    logic [`GST_LOOPS-1:0][15:0] hour_ref;
    logic [`GST_LOOPS-1:0][`GST_HOUR_W-1:0] hour_cnt;
  } gst_state_s;
endpackage

// file: gst_coordinator.sv
// group self-tuning coordinator with set-point supervision and parameter sets
//
// How it works
// - overshoot during tuning aborts, flags error, goes manual, outputs stable value.
// - one group of up to eight loops, membership set per loop.
// - host writing group start 1 sets tuning start of every member.
// - group start only taken when every member process is at rest.
// - members started blindly; a rejecting loop has its start cleared.
// - host clearing group start cancels all member tunings at once.
// - loops clear own start at a finished end, not at an error; group start cleared when all ended.
// - heating attempt released to all running members together once all rest.
// - faulted members do not hold back the heating release.
// - cooling released together when all three-point ready and others ended.
// - a lone three-point loop gets cooling enabled at once.
// - result codes 0 to 4 reported per loop.
// - result codes 5 to 8 reported per loop.
// - under one percent change in one hour after the step aborts with 3.
// - available output step below five percent aborts with 7.
// - finished results store new parameters; cancelled ones keep the old.
// - two parameter sets with defaults, chosen by host or digital input.
// - one-bit active parameter set selector, default 0.
// - one-bit tuning target set selector, default 0.
// - at rest after ninety seconds within half percent of span; leaving restarts.
// - after an error the stable value stays until host clears start.
`include "gst_params.svh"
module gst_coordinator #(
  parameter int TICK_CYCLES = `GST_CLK_HZ / `GST_TICK_PER_S,
  parameter int REST_TICKS = `GST_REST_TIME_S * `GST_TICK_PER_S,
  parameter int HOUR_TICKS = `GST_HOUR_TIME_S * `GST_TICK_PER_S
) (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  // avalon-mm slave
  input wire logic [7:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // process measurements per loop
  input wire logic [`GST_LOOPS-1:0][15:0] pv_i,
  input wire logic [`GST_LOOPS-1:0][15:0] sp_i,
  input wire logic [`GST_LOOPS-1:0][7:0] out_step_pct_i,
  // per-loop sequencer reports
  input wire logic [`GST_LOOPS-1:0] seq_reject_i,
  input wire logic [`GST_LOOPS-1:0] seq_cool_ready_i,
  input wire logic [`GST_LOOPS-1:0] seq_done_i,
  input wire logic [`GST_LOOPS-1:0][3:0] seq_code_i,
  input wire logic [`GST_LOOPS-1:0][15:0] seq_param_i,
  // digital parameter set select
  input wire logic param_dsel_i,
  // per-loop controls
  output logic [`GST_LOOPS-1:0] tune_start_o,
  output logic [`GST_LOOPS-1:0] heat_en_o,
  output logic [`GST_LOOPS-1:0] cool_en_o,
  output logic [`GST_LOOPS-1:0] manual_o,
  output logic [`GST_LOOPS-1:0][7:0] stable_out_o,
  output logic [`GST_LOOPS-1:0][15:0] ctrl_param_o,
  output logic group_active_o
);

  localparam int L = `GST_LOOPS;

  gst_pkg::gst_state_s s;
  gst_pkg::gst_state_s next_s;

  function automatic logic [15:0] absdiff(input logic [15:0] a, input logic [15:0] b);
    absdiff = (a > b) ? a - b : b - a;
  endfunction

  function automatic logic finished(input logic [3:0] c);
    finished = (c == `GST_CODE_OK) || (c == `GST_CODE_LOWREV) || (c == `GST_CODE_EARLY);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    logic [L-1:0] rest_v;
    logic [L-1:0] grp_v;
    logic [L-1:0] act_v;
    logic [L-1:0] heat_blk;
    logic [L-1:0] cool_blk;
    logic [L-1:0] pend;
    logic heat_ok;
    logic cool_ok;
    logic ab_v;
    logic [3:0] ab_c;
    logic [31:0] rv;
    logic [31:0] wm;
    logic [31:0] wv;
    logic [2:0] idx;
    rest_v = '0;
    grp_v = '0;
    act_v = '0;
    heat_blk = '0;
    cool_blk = '0;
    pend = '0;
    ab_v = 1'b0;
    ab_c = `GST_CODE_NONE;
    rv = 32'h0000_0000;
    wm = 32'h0000_0000;
    wv = 32'h0000_0000;
    idx = avs_address_i[4:2];
    next_s = s;
    next_s.ack = 1'b0;

    // 1 ms time base shared by the rest and reaction timers
    if (s.tick_cnt == `GST_TICK_W'(TICK_CYCLES - 1)) begin
      next_s.tick_cnt = '0;
      next_s.tick = 1'b1;
    end else begin
      next_s.tick_cnt = s.tick_cnt + `GST_TICK_W'(1);
      next_s.tick = 1'b0;
    end

    // digital input edges steer the active set; the host may override later
    next_s.dsel_q = param_dsel_i;
    if (param_dsel_i && !s.dsel_q) begin
      next_s.act_set = 1'b1;
    end else if (!param_dsel_i && s.dsel_q) begin
      next_s.act_set = 1'b0;
    end

    for (int i = 0; i < L; i++) begin
      rest_v[i] = s.rest_cnt[i] > `GST_REST_W'(REST_TICKS);
      grp_v[i] = s.grp_active && s.member[i];
      act_v[i] = (s.lst[i] != gst_pkg::GST_IDLE) && (s.lst[i] != gst_pkg::GST_ERR);
    end
    // faulted members sit in the error state and never block
    heat_blk = grp_v & ~rest_v;
    for (int i = 0; i < L; i++) begin
      heat_blk[i] = heat_blk[i] && (s.lst[i] == gst_pkg::GST_REST);
      cool_blk[i] = grp_v[i] && act_v[i] && !(s.three_pt[i] && s.lst[i] == gst_pkg::GST_COOLW);
      pend[i] = grp_v[i] && (act_v[i] || (s.start[i] && s.lst[i] != gst_pkg::GST_ERR));
    end
    heat_ok = ~|heat_blk;
    cool_ok = ~|cool_blk;

    ////////////////////////////////////////////////////////////////////////
    for (int i = 0; i < L; i++) begin
      ab_v = 1'b0;
      ab_c = `GST_CODE_NONE;
      // rest watchdog always runs; leaving the band restarts it
      if (absdiff(pv_i[i], s.rest_ref[i]) > s.span / 16'd200) begin
        next_s.rest_ref[i] = pv_i[i];
        next_s.rest_cnt[i] = '0;
      end else if (s.tick && !rest_v[i]) begin
        next_s.rest_cnt[i] = s.rest_cnt[i] + `GST_REST_W'(1);
      end

      case (s.lst[i])
        gst_pkg::GST_IDLE: begin
          if (s.start[i] && seq_reject_i[i]) begin
            next_s.start[i] = 1'b0;
          end else if (s.start[i]) begin
            next_s.lst[i] = gst_pkg::GST_REST;
          end
        end
        gst_pkg::GST_REST: begin
          if ((grp_v[i] && heat_ok) || (!grp_v[i] && rest_v[i])) begin
            next_s.lst[i] = gst_pkg::GST_HEAT;
            next_s.hour_ref[i] = pv_i[i];
            next_s.hour_cnt[i] = '0;
            next_s.reacted[i] = 1'b0;
            if (out_step_pct_i[i] < `GST_MIN_STEP_PCT) begin
              ab_v = 1'b1;
              ab_c = `GST_CODE_STEP;
            end
          end
        end
        gst_pkg::GST_HEAT: begin
          if (!s.reacted[i]) begin
            if (absdiff(pv_i[i], s.hour_ref[i]) >= s.span / 16'd100) begin
              next_s.reacted[i] = 1'b1;
            end else if (s.hour_cnt[i] >= `GST_HOUR_W'(HOUR_TICKS)) begin
              ab_v = 1'b1;
              ab_c = `GST_CODE_SLOW;
            end else if (s.tick) begin
              next_s.hour_cnt[i] = s.hour_cnt[i] + `GST_HOUR_W'(1);
            end
          end
          if (s.three_pt[i] && seq_cool_ready_i[i]) begin
            // a loop running alone skips the common cooling release
            next_s.lst[i] = grp_v[i] ? gst_pkg::GST_COOLW : gst_pkg::GST_COOL;
          end
        end
        gst_pkg::GST_COOLW: begin
          if (cool_ok || !grp_v[i]) begin
            next_s.lst[i] = gst_pkg::GST_COOL;
          end
        end
        gst_pkg::GST_COOL: begin
          next_s.lst[i] = gst_pkg::GST_COOL;
        end
        gst_pkg::GST_ERR: begin
          // stable value is held here until the host drops the start bit
          if (!s.start[i]) begin
            next_s.lst[i] = gst_pkg::GST_IDLE;
          end
        end
        default: begin
          next_s.lst[i] = gst_pkg::GST_IDLE;
        end
      endcase

      if (act_v[i]) begin
        if (!s.start[i]) begin
          next_s.lst[i] = gst_pkg::GST_IDLE;
          next_s.code[i] = `GST_CODE_NONE;
        end else if (seq_done_i[i]) begin
          next_s.code[i] = seq_code_i[i];
          if (finished(seq_code_i[i])) begin
            next_s.pset[s.tgt_set][i] = seq_param_i[i];
            next_s.lst[i] = gst_pkg::GST_IDLE;
            next_s.start[i] = 1'b0;
          end else begin
            next_s.lst[i] = gst_pkg::GST_ERR;
          end
        end else if (pv_i[i] > sp_i[i]) begin
          ab_v = 1'b1;
          ab_c = (s.lst[i] == gst_pkg::GST_REST) ? `GST_CODE_REST : `GST_CODE_OVR;
        end else if (ab_v) begin
          ab_c = ab_c;
        end
        if (s.start[i] && !seq_done_i[i] && ab_v) begin
          next_s.lst[i] = gst_pkg::GST_ERR;
          next_s.code[i] = ab_c;
        end
      end
    end

    // all members ended: group start drops, error loops keep their own start
    if (s.grp_active && ~|pend) begin
      next_s.grp_active = 1'b0;
      next_s.grp_start = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    case (avs_address_i)
      `GST_OFS_CTRL: rv = {29'h0, s.tgt_set, s.act_set, s.grp_start};
      `GST_OFS_MEMBER: rv = {24'h0, s.member};
      `GST_OFS_START: rv = {24'h0, s.start};
      `GST_OFS_THREEPT: rv = {24'h0, s.three_pt};
      `GST_OFS_STATUS: begin
        for (int i = 0; i < L; i++) begin
          rv[i] = s.lst[i] == gst_pkg::GST_ERR;
        end
        rv[15:8] = rest_v;
        rv[16] = s.grp_active;
      end
      `GST_OFS_SPAN: rv = {16'h0, s.span};
      default: begin
        case ({avs_address_i[7:5], 5'h00})
          `GST_BASE_STABLE: rv = {24'h0, s.stable[idx]};
          `GST_BASE_CODE: rv = {28'h0, s.code[idx]};
          `GST_BASE_PSET0: rv = {16'h0, s.pset[0][idx]};
          `GST_BASE_PSET1: rv = {16'h0, s.pset[1][idx]};
          default: rv = 32'h0000_0000;
        endcase
      end
    endcase

    if ((avs_read_i || avs_write_i) && !s.ack) begin
      next_s.ack = 1'b1;
      next_s.rdata = avs_read_i ? rv : 32'h0000_0000;
    end

    for (int b = 0; b < 4; b++) begin
      wm[b*8 +: 8] = {8{avs_byteenable_i[b]}};
    end
    wv = (rv & ~wm) | (avs_writedata_i & wm);

    // host writes land last so a same-cycle start write beats a hardware clear
    if (avs_write_i && s.ack) begin
      case (avs_address_i)
        `GST_OFS_CTRL: begin
          next_s.act_set = wv[`GST_CTRL_ACT];
          next_s.tgt_set = wv[`GST_CTRL_TGT];
          if (wv[`GST_CTRL_GRP] && !s.grp_start) begin
            // refused unless every member is already at rest
            if (~|(s.member & ~rest_v)) begin
              next_s.grp_start = 1'b1;
              next_s.grp_active = 1'b1;
              next_s.start = next_s.start | s.member;
            end
          end else if (!wv[`GST_CTRL_GRP] && s.grp_start) begin
            next_s.grp_start = 1'b0;
            next_s.grp_active = 1'b0;
            next_s.start = next_s.start & ~s.member;
          end
        end
        `GST_OFS_MEMBER: next_s.member = wv[7:0];
        `GST_OFS_START: next_s.start = wv[7:0];
        `GST_OFS_THREEPT: next_s.three_pt = wv[7:0];
        `GST_OFS_SPAN: next_s.span = wv[15:0];
        default: begin
          case ({avs_address_i[7:5], 5'h00})
            `GST_BASE_STABLE: next_s.stable[idx] = wv[7:0];
            `GST_BASE_PSET0: next_s.pset[0][idx] = wv[15:0];
            `GST_BASE_PSET1: next_s.pset[1][idx] = wv[15:0];
            default: next_s.member = next_s.member;
          endcase
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s <= '0;
      s.span <= `GST_RST_SPAN;
      for (int i = 0; i < L; i++) begin
        s.lst[i] <= gst_pkg::GST_IDLE;
        s.stable[i] <= `GST_RST_STABLE;
        s.pset[0][i] <= `GST_RST_PSET0;
        s.pset[1][i] <= `GST_RST_PSET1;
      end
    end else begin
      s <= next_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign avs_waitrequest_o = (avs_read_i || avs_write_i) && !s.ack;
  assign avs_readdata_o = s.rdata;
  assign tune_start_o = s.start;
  assign group_active_o = s.grp_active;

  always_comb begin
    for (int i = 0; i < L; i++) begin
      heat_en_o[i] = s.lst[i] == gst_pkg::GST_HEAT;
      cool_en_o[i] = s.lst[i] == gst_pkg::GST_COOL;
      manual_o[i] = s.lst[i] == gst_pkg::GST_ERR;
      stable_out_o[i] = s.stable[i];
      ctrl_param_o[i] = s.pset[s.act_set][i];
    end
  end

endmodule

// file: gst_coordinator_props.sv
// port-level assertion checker for the group self-tuning coordinator
`include "gst_params.svh"
module gst_coordinator_props (
  // clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  // register bus
  input wire logic [7:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic avs_waitrequest_o,
  // loop controls
  input wire logic [`GST_LOOPS-1:0] tune_start_o,
  input wire logic [`GST_LOOPS-1:0] heat_en_o,
  input wire logic [`GST_LOOPS-1:0] cool_en_o,
  input wire logic [`GST_LOOPS-1:0] manual_o,
  input wire logic group_active_o
);
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!rst_n_i);
  ////////////////////////////////////////////////////////////
  sequence s_host_stop;
    avs_write_i && !avs_waitrequest_o && avs_address_i[7:2] == 6'h00 && !avs_writedata_i[0] && group_active_o;
  endsequence
  sequence s_all_idle;
    tune_start_o == '0 ##1 (heat_en_o | cool_en_o) == '0;
  endsequence
  property p_one_wait;
    (avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o;
  endproperty
  a_one_wait: assert property (p_one_wait) else $error("register access saw a second wait cycle");
  property p_unmapped;
    avs_read_i && !avs_waitrequest_o && avs_address_i >= 8'hA0 |-> avs_readdata_o == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read returned nonzero");
  property p_group_stop;
    s_host_stop |=> ##[0:1] s_all_idle;
  endproperty
  a_group_stop: assert property (p_group_stop) else $error("group stop left loops running");
  property p_heat_together;
    group_active_o && $past(heat_en_o) == '0 && heat_en_o != '0 |-> heat_en_o == (tune_start_o & ~manual_o);
  endproperty
  a_heat_together: assert property (p_heat_together) else $error("heating not released together");
  property p_manual_quiet;
    (manual_o & (heat_en_o | cool_en_o)) == '0;
  endproperty
  a_manual_quiet: assert property (p_manual_quiet) else $error("loop in manual still attempting");
  property p_error_holds;
    ($past(manual_o) & $past(tune_start_o) & ~manual_o) == '0;
  endproperty
  a_error_holds: assert property (p_error_holds) else $error("manual left while start still set");
  property p_cool_group;
    group_active_o && $past(cool_en_o) == '0 && cool_en_o != '0 |-> heat_en_o == '0;
  endproperty
  a_cool_group: assert property (p_cool_group) else $error("cooling released while heating ran");
  property p_group_end;
    group_active_o && tune_start_o == '0 |-> ##[0:2] !group_active_o;
  endproperty
  a_group_end: assert property (p_group_end) else $error("group stayed active after all ended");
endmodule
bind gst_coordinator gst_coordinator_props i_props (.clk_sys_i, .rst_n_i, .avs_address_i, .avs_read_i,
  .avs_write_i, .avs_writedata_i, .avs_readdata_o, .avs_waitrequest_o, .tune_start_o, .heat_en_o, .cool_en_o,
  .manual_o, .group_active_o);

// file: gst_seq_model.sv
// behavioural model of the per-loop self-tuning sequencers
`include "gst_params.svh"
module gst_seq_model (
  // clock
  input wire logic clk_sys_i,
  // coordinator controls
  input wire logic [`GST_LOOPS-1:0] tune_start_i,
  input wire logic [`GST_LOOPS-1:0] heat_en_i,
  // sequencer reports
  output logic [`GST_LOOPS-1:0] seq_reject_o,
  output logic [`GST_LOOPS-1:0] seq_cool_ready_o,
  output logic [`GST_LOOPS-1:0] seq_done_o,
  output logic [`GST_LOOPS-1:0][3:0] seq_code_o,
  output logic [`GST_LOOPS-1:0][15:0] seq_param_o
);
  logic [`GST_LOOPS-1:0] reject_mask = '0;
  logic [`GST_LOOPS-1:0] cool_mask = '0;
  logic [3:0] fin_code = 4'h0;
  logic [15:0] fin_par = 16'h0;
  logic [15:0] pat = 16'h0;
  initial seq_done_o = '0;
  assign seq_reject_o = reject_mask & tune_start_i;
  assign seq_cool_ready_o = cool_mask & heat_en_i;
  // result lines carry a changing pattern outside the done pulse, never the last value
  always @(posedge clk_sys_i) pat <= pat + 16'h1357;
  always_comb begin
    for (int i = 0; i < `GST_LOOPS; i++) begin
      seq_code_o[i] = seq_done_o[i] ? fin_code : pat[3:0];
      seq_param_o[i] = seq_done_o[i] ? fin_par : pat;
    end
  end
  task automatic finish(input logic [`GST_LOOPS-1:0] mask, input logic [3:0] code, input logic [15:0] par);
    @(posedge clk_sys_i);
    seq_done_o <= mask;
    fin_code <= code;
    fin_par <= par;
    @(posedge clk_sys_i);
    seq_done_o <= '0;
  endtask
endmodule

// file: tb_gst_coordinator.sv
// self-checking testbench for the group self-tuning coordinator
`include "gst_params.svh"
module tb_gst_coordinator;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [7:0] avs_address_i = 8'h00;
  logic avs_read_i = 1'b0;
  logic avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = 32'h0;
  logic [3:0] avs_byteenable_i = 4'hF;
  logic [31:0] avs_readdata_o;
  logic avs_waitrequest_o;
  logic [`GST_LOOPS-1:0][15:0] pv_i = {8{16'h0100}};
  logic [`GST_LOOPS-1:0][15:0] sp_i = {8{16'h0800}};
  logic [`GST_LOOPS-1:0][7:0] out_step_pct_i = {8{8'h32}};
  logic [`GST_LOOPS-1:0] seq_reject_i, seq_cool_ready_i, seq_done_i;
  logic [`GST_LOOPS-1:0][3:0] seq_code_i;
  logic [`GST_LOOPS-1:0][15:0] seq_param_i;
  logic param_dsel_i = 1'b0;
  logic [`GST_LOOPS-1:0] tune_start_o, heat_en_o, cool_en_o, manual_o;
  logic [`GST_LOOPS-1:0][7:0] stable_out_o;
  logic [`GST_LOOPS-1:0][15:0] ctrl_param_o;
  logic group_active_o;
  logic [31:0] rd;
  int fail_count = 0;
  int n_compared = 0;
  gst_coordinator #(.TICK_CYCLES(4), .REST_TICKS(5), .HOUR_TICKS(20)) i_dut (.clk_sys_i, .rst_n_i, .avs_address_i,
    .avs_read_i, .avs_write_i, .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o, .pv_i,
    .sp_i, .out_step_pct_i, .seq_reject_i, .seq_cool_ready_i, .seq_done_i, .seq_code_i, .seq_param_i,
    .param_dsel_i, .tune_start_o, .heat_en_o, .cool_en_o, .manual_o, .stable_out_o, .ctrl_param_o, .group_active_o);
  gst_seq_model i_seq (.clk_sys_i, .tune_start_i(tune_start_o), .heat_en_i(heat_en_o), .seq_reject_o(seq_reject_i),
    .seq_cool_ready_o(seq_cool_ready_i), .seq_done_o(seq_done_i), .seq_code_o(seq_code_i), .seq_param_o(seq_param_i));
  initial begin
    forever #10 clk_sys_i = ~clk_sys_i;
  end
  ////////////////////////////////////////////////////////////
  task automatic check(input string w, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", w, exp, seen);
    end
  endtask
  // request held until waitrequest is sampled low, then released
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys_i);
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_byteenable_i <= 4'hF;
    if (wr) avs_write_i <= 1'b1;
    else avs_read_i <= 1'b1;
    // no local limit: only the watchdog ends a stuck wait
    @(posedge clk_sys_i);
    while (avs_waitrequest_o !== 1'b0) begin
      @(posedge clk_sys_i);
    end
    rd = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
  endtask
  task automatic rchk(input string w, input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    check(w, rd, e);
  endtask
  task automatic end_of_test();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    repeat (5000) @(posedge clk_sys_i);
    fail_count++;
    end_of_test();
  end
  initial begin
    repeat (20) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    rchk("ctrl_reset", `GST_OFS_CTRL, 32'h0);
    bus(1'b1, `GST_OFS_MEMBER, 32'h0B);
    bus(1'b1, `GST_OFS_CTRL, 32'h1);
    rchk("early_start", `GST_OFS_CTRL, 32'h0);
    rchk("span", `GST_OFS_SPAN, 32'(`GST_RST_SPAN));
    rchk("pset1", `GST_BASE_PSET1, 32'(`GST_RST_PSET1));
    rchk("unmapped", 8'hFC, 32'h0);
    check("param", 32'(ctrl_param_o[0]), 32'(`GST_RST_PSET0));
    // group run: loop 1 refuses, loop 3 is three-point
    bus(1'b1, `GST_OFS_THREEPT, 32'h08);
    i_seq.reject_mask <= 8'h02;
    repeat (40) @(posedge clk_sys_i);
    bus(1'b1, `GST_OFS_CTRL, 32'h1);
    for (int k = 0; k < 400 && heat_en_o !== 8'h09; k++) @(posedge clk_sys_i);
    check("heat", 32'(heat_en_o), 32'h09);
    check("reject", 32'(tune_start_o), 32'h09);
    i_seq.cool_mask <= 8'h08;
    repeat (10) @(posedge clk_sys_i);
    check("cool_wait", 32'(cool_en_o), 32'h00);
    i_seq.finish(8'h01, `GST_CODE_OK, 16'h1234);
    for (int k = 0; k < 20 && cool_en_o !== 8'h08; k++) @(posedge clk_sys_i);
    check("cool", 32'(cool_en_o), 32'h08);
    rchk("pset0", `GST_BASE_PSET0, 32'h1234);
    i_seq.finish(8'h08, `GST_CODE_LOWREV, 16'h0042);
    for (int k = 0; k < 20 && group_active_o !== 1'b0; k++) @(posedge clk_sys_i);
    check("grp_active", 32'(group_active_o), 32'h0);
    rchk("pset0_3", `GST_BASE_PSET0 + 8'h0C, 32'h0042);
    rchk("group_end", `GST_OFS_CTRL, 32'h0);
    // selection by the digital input, then back by the host
    param_dsel_i <= 1'b1;
    repeat (5) @(posedge clk_sys_i);
    check("dsel", 32'(ctrl_param_o[0]), 32'(`GST_RST_PSET1));
    rchk("act_set", `GST_OFS_CTRL, 32'h2);
    bus(1'b1, `GST_OFS_CTRL, 32'h0);
    repeat (3) @(posedge clk_sys_i);
    check("host_sel", 32'(ctrl_param_o[0]), 32'h1234);
    // group stop in mid-run
    i_seq.reject_mask <= 8'h00;
    i_seq.cool_mask <= 8'h00;
    repeat (40) @(posedge clk_sys_i);
    bus(1'b1, `GST_OFS_CTRL, 32'h1);
    for (int k = 0; k < 400 && heat_en_o !== 8'h0B; k++) @(posedge clk_sys_i);
    check("heat_all", 32'(heat_en_o), 32'h0B);
    bus(1'b1, `GST_OFS_CTRL, 32'h0);
    repeat (3) @(posedge clk_sys_i);
    check("stop", 32'({tune_start_o, heat_en_o}), 32'h0);
    rchk("stop_code", `GST_BASE_CODE, 32'(`GST_CODE_NONE));
    // three-point loop started alone cools without waiting
    i_seq.cool_mask <= 8'h08;
    bus(1'b1, `GST_OFS_START, 32'h08);
    for (int k = 0; k < 400 && cool_en_o !== 8'h08; k++) @(posedge clk_sys_i);
    check("alone_cool", 32'(cool_en_o), 32'h08);
    bus(1'b1, `GST_OFS_START, 32'h0);
    // aborts: slow process, overshoot, small output step
    pv_i[4] <= 16'h0900;
    out_step_pct_i[5] <= 8'h04;
    bus(1'b1, `GST_BASE_STABLE + 8'h10, 32'h5A);
    bus(1'b1, `GST_OFS_START, 32'h34);
    for (int k = 0; k < 600 && manual_o !== 8'h34; k++) @(posedge clk_sys_i);
    rchk("slow", `GST_BASE_CODE + 8'h08, 32'(`GST_CODE_SLOW));
    rchk("over", `GST_BASE_CODE + 8'h10, 32'(`GST_CODE_REST));
    rchk("step", `GST_BASE_CODE + 8'h14, 32'(`GST_CODE_STEP));
    check("stable", 32'(stable_out_o[4]), 32'h5A);
    rchk("pset_kept", `GST_BASE_PSET0 + 8'h08, 32'(`GST_RST_PSET0));
    bus(1'b1, `GST_OFS_START, 32'h0);
    repeat (3) @(posedge clk_sys_i);
    check("manual_off", 32'(manual_o), 32'h0);
    // results go to set 1: a finished run lands there, a faulted one leaves it alone
    bus(1'b1, `GST_OFS_CTRL, 32'h4);
    bus(1'b1, `GST_OFS_START, 32'h40);
    for (int k = 0; k < 50 && heat_en_o !== 8'h40; k++) @(posedge clk_sys_i);
    i_seq.finish(8'h40, `GST_CODE_EARLY, 16'h0777);
    rchk("pset1_6", `GST_BASE_PSET1 + 8'h18, 32'h0777);
    rchk("pset0_6", `GST_BASE_PSET0 + 8'h18, 32'(`GST_RST_PSET0));
    rchk("code_6", `GST_BASE_CODE + 8'h18, 32'(`GST_CODE_EARLY));
    bus(1'b1, `GST_OFS_START, 32'h80);
    for (int k = 0; k < 50 && heat_en_o !== 8'h80; k++) @(posedge clk_sys_i);
    i_seq.finish(8'h80, 4'h1, 16'h0999);
    repeat (2) @(posedge clk_sys_i);
    check("manual_7", 32'(manual_o), 32'h80);
    rchk("pset1_7", `GST_BASE_PSET1 + 8'h1C, 32'(`GST_RST_PSET1));
    rchk("code_1", `GST_BASE_CODE + 8'h1C, 32'h1);
    rchk("status", `GST_OFS_STATUS, 32'h0000_FF80);
    end_of_test();
  end
endmodule
